// ---- hdl/bit_sync.sv ----
// Purpose: Two-flop level synchroniser, one per bit
// Assumes: Each bit is an independent level or toggle
// Notes: First stage feeds only the second stage
module bit_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    sync_q <= meta_q;
  end

  assign o_q = sync_q;

endmodule : bit_sync

// ---- hdl/mem_array.sv ----
// Purpose: Byte array with one write port and an async read
// Assumes: Written on rising serial clock
// Notes: Contents survive select and reset
module mem_array
  import spi_mem_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [spi_mem_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [MEM_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_addr];

endmodule : mem_array

// ---- hdl/spi_mem_pkg.sv ----
// Purpose: Shared constants for the serial memory command port
// Assumes: Opcodes are one byte, sent MSB first
// Notes: Status bits 6,5,4,0 are user bits without effect
package spi_mem_pkg;

  // ==========================================
  // Array geometry
  localparam int unsigned MEM_DEPTH = 131072;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned BYTE_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 17'h1ffff;

  // ==========================================
  // Opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;

  // ==========================================
  // Status layout
  localparam int unsigned ST_LOCK = 7;
  localparam int unsigned ST_BP_HI = 3;
  localparam int unsigned ST_BP_LO = 2;
  localparam int unsigned ST_WEL = 1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] STATUS_WR_MASK = 8'hfd;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;

  // ==========================================
  // Link sequencing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam int unsigned EV_SET = 0;
  localparam int unsigned EV_CLR = 1;
  localparam int unsigned EV_STWR = 2;
  localparam int unsigned EV_SLEEP = 3;
  localparam int unsigned EV_WAKE = 4;
  localparam int unsigned EV_N = 5;

  typedef enum logic [2:0] {
    LS_OPCODE = 3'b000,
    LS_ADDR = 3'b001,
    LS_RDATA = 3'b010,
    LS_WDATA = 3'b011,
    LS_STWR = 3'b100,
    LS_STRD = 3'b101,
    LS_IGNORE = 3'b110
  } link_state_t;

endpackage : spi_mem_pkg

// ---- hdl/spi_mem_port.sv ----
// Purpose: Target side command port of a serial byte memory
// Assumes: Link logic clocked by i_sck, core by i_mclk
// Notes: Select high resets the link side while pause is high
//
// Notes on behaviour
// - Array of 131072 bytes, eight bits each
// - Select high: ignore inputs, output off, idle
// - Output driven only for array read data and status reads
// - Output changes on falling clock only
// - Input sampled on rising clock only
// - Write-protect low blocks status writes while lock bit set
// - Pause low suspends, ignores select and clock
// - Mode 0 or 3 from clock at select
// - Static logic, clock may stop anytime
// - One command per select-low period
// - 06h sets latch, 04h clears it
// - 05h shifts out the status byte, repeating until deselect
// - 01h takes one new status byte
// - 03h reads streaming after three address bytes
// - 02h writes streaming after three address bytes
// - B9h enters sleep, ABh leaves it
// - Only low seventeen address bits used
// - Address advances per byte, wraps to zero
// - Writes need latch set; reset clears latch
// - Block-protect field guards array region
module spi_mem_port
  import spi_mem_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe,
  output logic o_sleep,
  output logic o_mode3,
  output logic o_selected,
  output logic o_write_enable_latch,
  output logic [1:0] o_block_protect_field,
  output logic o_status_lock_enable
);
  import spi_mem_pkg::*;

  // ==========================================
  // Link side declarations
  logic link_rst;
  link_state_t st_q;
  link_state_t st_d;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [1:0] addr_cnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic is_write_q;
  logic [EV_N-1:0] ev_tgl_q;
  logic [7:0] stwr_data_q;
  logic so_q;
  logic oe_q;
  logic [6:0] out_sh_q;
  logic [7:0] status_s;
  logic sleep_s;
  logic [7:0] byte_in;
  logic byte_end;
  logic step;
  logic [EV_N-1:0] ev_fire;
  logic [EV_N-1:0] opc_ev;
  logic [7:0] mem_rdata;
  logic [7:0] out_byte;
  logic [1:0] bp_s;
  logic prot_hit;
  logic mem_we;
  logic rd_phase;

  // ==========================================
  // Core side declarations
  logic [EV_N-1:0] ev_tgl_s;
  logic [EV_N-1:0] ev_seen_q;
  logic [EV_N-1:0] ev_pulse;
  logic cs_s;
  logic sck_s;
  logic wp_s;
  logic cs_prev_q;
  logic cs_fall;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic sleep_q;
  logic mode3_q;
  logic selected_q;
  logic stwr_ok;

  // ==========================================
  // Link reset and stepping
  // Pause low masks select rising as well
  assign link_rst = i_rst | (i_cs_n & i_hold_n);
  assign step = i_hold_n;
  assign byte_in = {shift_q, i_si};
  assign byte_end = (bit_cnt_q == BIT_LAST);
  assign ev_fire = (step && byte_end) ? opc_ev : '0;

  // ==========================================
  // Opcode decode
  always_comb begin
    st_d = st_q;
    opc_ev = '0;
    case (st_q)
      LS_OPCODE: begin
        if (sleep_s && byte_in != OP_WAKE) begin
          st_d = LS_IGNORE;
        end else begin
          case (byte_in)
            OP_LATCH_SET: begin
              opc_ev[EV_SET] = 1'b1;
              st_d = LS_IGNORE;
            end
            OP_LATCH_CLR: begin
              opc_ev[EV_CLR] = 1'b1;
              st_d = LS_IGNORE;
            end
            OP_STATUS_RD: st_d = LS_STRD;
            OP_STATUS_WR: st_d = LS_STWR;
            OP_READ: st_d = LS_ADDR;
            OP_WRITE: st_d = LS_ADDR;
            OP_SLEEP: begin
              opc_ev[EV_SLEEP] = 1'b1;
              st_d = LS_IGNORE;
            end
            OP_WAKE: begin
              opc_ev[EV_WAKE] = 1'b1;
              st_d = LS_IGNORE;
            end
            default: st_d = LS_IGNORE;
          endcase
        end
      end
      LS_ADDR: begin
        if (addr_cnt_q == ADDR_LAST) begin
          st_d = is_write_q ? LS_WDATA : LS_RDATA;
        end
      end
      LS_STWR: begin
        opc_ev[EV_STWR] = 1'b1;
        st_d = LS_IGNORE;
      end
      default: st_d = st_q;
    endcase
  end

  // ==========================================
  // Link input side, rising clock
  always_ff @(posedge i_sck or posedge link_rst) begin
    if (link_rst) begin
      st_q <= LS_OPCODE;
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      addr_cnt_q <= 2'h0;
      addr_q <= '0;
      is_write_q <= 1'b0;
    end else if (step) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= byte_in[6:0];
      if (byte_end) begin
        st_q <= st_d;
        if (st_q == LS_OPCODE) begin
          is_write_q <= (byte_in == OP_WRITE);
        end
        if (st_q == LS_ADDR) begin
          addr_cnt_q <= addr_cnt_q + 2'h1;
          addr_q <= {addr_q[8:0], byte_in};
        end
        if (st_q == LS_RDATA || st_q == LS_WDATA) begin
          addr_q <= addr_q + 17'h00001;
        end
      end
    end
  end

  // Event toggles survive deselect
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      ev_tgl_q <= '0;
      stwr_data_q <= STATUS_RST;
    end else begin
      ev_tgl_q <= ev_tgl_q ^ ev_fire;
      if (ev_fire[EV_STWR]) begin
        stwr_data_q <= byte_in;
      end
    end
  end

  // ==========================================
  // Array and protection
  assign bp_s = status_s[ST_BP_HI:ST_BP_LO];
  assign prot_hit = (bp_s == BP_ALL) ||
                    (bp_s == BP_HALF && addr_q[16]) ||
                    (bp_s == BP_QUARTER && addr_q[16:15] == 2'b11);
  assign mem_we = step && byte_end && st_q == LS_WDATA &&
                  status_s[ST_WEL] && !prot_hit;

  mem_array u_mem (
    .i_clk(i_sck),
    .i_we(mem_we),
    .i_addr(addr_q),
    .i_wdata(byte_in),
    .o_rdata(mem_rdata)
  );

  // ==========================================
  // Link output side, falling clock
  assign rd_phase = (st_q == LS_RDATA) || (st_q == LS_STRD);
  assign out_byte = (st_q == LS_STRD) ? status_s : mem_rdata;

  always_ff @(negedge i_sck or posedge link_rst) begin
    if (link_rst) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
      out_sh_q <= 7'h00;
    end else if (step) begin
      oe_q <= rd_phase;
      if (rd_phase && bit_cnt_q == 3'h0) begin
        so_q <= out_byte[7];
        out_sh_q <= out_byte[6:0];
      end else if (rd_phase) begin
        so_q <= out_sh_q[6];
        out_sh_q <= {out_sh_q[5:0], 1'b0};
      end
    end
  end

  assign o_so = so_q;
  // Pins gate the enable so release is immediate
  assign o_so_oe = oe_q & ~i_cs_n & i_hold_n;

  // ==========================================
  // Crossings
  bit_sync #(.W(9)) u_to_link (
    .i_clk(i_sck),
    .i_d({sleep_q, status_q}),
    .o_q({sleep_s, status_s})
  );

  bit_sync #(.W(EV_N + 3)) u_to_core (
    .i_clk(i_mclk),
    .i_d({ev_tgl_q, i_cs_n, i_sck, i_wp_n}),
    .o_q({ev_tgl_s, cs_s, sck_s, wp_s})
  );

  // ==========================================
  // Core status and mode
  assign ev_pulse = ev_tgl_s ^ ev_seen_q;
  assign cs_fall = cs_prev_q & ~cs_s;
  assign stwr_ok = status_q[ST_WEL] && !(status_q[ST_LOCK] && !wp_s);

  always_comb begin
    status_d = status_q;
    if (ev_pulse[EV_STWR] && stwr_ok) begin
      status_d = (stwr_data_q & STATUS_WR_MASK) | (status_q & ~STATUS_WR_MASK);
    end
    if (ev_pulse[EV_SET]) begin
      status_d[ST_WEL] = 1'b1;
    end
    if (ev_pulse[EV_CLR]) begin
      status_d[ST_WEL] = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ev_seen_q <= '0;
      cs_prev_q <= 1'b1;
      status_q <= STATUS_RST;
      sleep_q <= 1'b0;
      mode3_q <= 1'b0;
      selected_q <= 1'b0;
    end else begin
      ev_seen_q <= ev_tgl_s;
      cs_prev_q <= cs_s;
      status_q <= status_d;
      selected_q <= ~cs_s;
      if (ev_pulse[EV_SLEEP]) begin
        sleep_q <= 1'b1;
      end else if (ev_pulse[EV_WAKE]) begin
        sleep_q <= 1'b0;
      end
      if (cs_fall) begin
        mode3_q <= sck_s;
      end
    end
  end

  assign o_sleep = sleep_q;
  assign o_mode3 = mode3_q;
  assign o_selected = selected_q;
  assign o_write_enable_latch = status_q[ST_WEL];
  assign o_block_protect_field = status_q[ST_BP_HI:ST_BP_LO];
  assign o_status_lock_enable = status_q[ST_LOCK];

  // ==========================================
  // Checks
  chk_deselect_quiet: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_cs_n |-> (!o_so_oe && (!i_hold_n || !oe_q)))
    else $error("output enabled while deselected");

  chk_pause_quiet: assert property (
    @(posedge i_mclk) disable iff (i_rst) !i_hold_n |-> !o_so_oe)
    else $error("output enabled while paused");

  chk_out_falling: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ($changed(o_so) && !i_cs_n && $past(!i_cs_n)) |-> !i_sck)
    else $error("output moved outside a falling edge");

  chk_latch_set: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (ev_pulse[EV_SET] && !ev_pulse[EV_CLR]) |=> o_write_enable_latch)
    else $error("latch not set");

  chk_latch_clear: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ev_pulse[EV_CLR] |=> !o_write_enable_latch)
    else $error("latch not cleared");

  chk_status_lock: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (ev_pulse[EV_STWR] && status_q[ST_LOCK] && !wp_s && !ev_pulse[EV_SET]
     && !ev_pulse[EV_CLR]) |=> $stable(status_q))
    else $error("locked status modified");

  chk_sleep_track: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ev_pulse[EV_SLEEP] |=> o_sleep ##1 o_sleep)
    else $error("sleep not entered");

  chk_mode_pick: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    cs_fall |=> (o_mode3 == $past(sck_s)))
    else $error("mode not captured");

  chk_addr_wrap: assert property (
    @(posedge i_sck) disable iff (link_rst)
    (step && byte_end && (st_q == LS_RDATA || st_q == LS_WDATA) && addr_q == ADDR_TOP)
    |=> addr_q == '0)
    else $error("address did not wrap");

  chk_unknown_idle: assert property (
    @(negedge i_sck) disable iff (link_rst)
    (st_q == LS_IGNORE) |=> !oe_q)
    else $error("output driven after ignored opcode");

  cov_array_read: cover property (
    @(posedge i_sck) disable iff (link_rst) st_q == LS_RDATA && byte_end);

  cov_array_write: cover property (
    @(posedge i_sck) disable iff (link_rst) mem_we);

  cov_status_write: cover property (
    @(posedge i_mclk) disable iff (i_rst) ev_pulse[EV_STWR] && stwr_ok);

  cov_mode3: cover property (
    @(posedge i_mclk) disable iff (i_rst) cs_fall && sck_s);

endmodule : spi_mem_port

// ---- tb/spi_host_model.sv ----
// Purpose: Behavioural SPI host for the memory command port
// Assumes: Mode 0 or 3, 125 ns serial clock, MSB first
// Notes: Serial clock stands still between frames
module spi_host_model (
  input wire logic i_so,
  input wire logic i_so_oe,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  output logic o_hold_n
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;
  logic m3;

  initial begin
    m3 = 1'b0;
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end

  // ==========================================
  // Frame tasks
  task automatic start();
    o_sck = m3;
    #100;
    o_cs_n = 1'b0;
    #HALF;
  endtask : start

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (o_sck) begin
        o_sck = 1'b0;
      end
      o_si = tx[i];
      #HALF;
      rx[i] = i_so_oe ? i_so : 1'bz;
      o_sck = 1'b1;
      #HALF;
    end
  endtask : xbyte

  task automatic stop();
    if (o_sck !== m3) begin
      o_sck = m3;
      #HALF;
    end
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #250;
  endtask : stop

  task automatic set_hold(input logic v);
    if (o_sck !== m3) begin
      o_sck = m3;
      #HALF;
    end
    o_hold_n = v;
    #100;
  endtask : set_hold
endmodule : spi_host_model

// ---- tb/spi_serial_memory_command_port_tb.sv ----
// Purpose: Self-checking bench for the memory command port
// Assumes: Host model drives the link, bench drives core pins
// Notes: Ordinary write and read-back cases come from a table
module spi_serial_memory_command_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_mem_pkg::*;
  typedef struct packed {logic m3; logic [23:0] addr; logic [7:0] data;} row_t;
  logic i_mclk, i_rst, i_wp_n, oe_seen;
  logic sck, cs_n, si, hold_n, so, so_oe, sleep, mode3, selected, write_enable_latch, lock;
  logic [1:0] bp;
  logic [7:0] rx;
  int miscompares, tests_run;
  row_t rows [4] = '{'{1'b0, 24'h000000, 8'ha5}, '{1'b1, 24'h01fffe, 8'h3c},
                     '{1'b0, 24'hfe0123, 8'h5a}, '{1'b1, 24'h010000, 8'hc3}};

  spi_mem_port uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe),
    .o_sleep(sleep), .o_mode3(mode3), .o_selected(selected),
    .o_write_enable_latch(write_enable_latch), .o_block_protect_field(bp), .o_status_lock_enable(lock));
  spi_host_model host (.i_so(so), .i_so_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n),
    .o_si(si), .o_hold_n(hold_n));

  always #2 i_mclk = ~i_mclk;
  always @(posedge so_oe) oe_seen = 1'b1;

  // ==========================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic frame(input logic [47:0] b, input int n, output logic [7:0] r);
    host.start();
    for (int i = n - 1; i >= 0; i--) begin
      host.xbyte(b[8*i +: 8], r);
    end
    host.stop();
  endtask : frame

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    #250000;
    miscompares++;
    end_sim();
  end

  // ==========================================
  // Main sequence
  initial begin
    i_mclk = 1'b0;
    i_rst = 1'b1;
    i_wp_n = 1'b1;
    oe_seen = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (6) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_mclk);
    chk("reset", 8'h00, {so_oe, sleep, mode3, selected, write_enable_latch, bp, lock});
    foreach (rows[k]) begin
      host.m3 = rows[k].m3;
      frame({40'h0, OP_LATCH_SET}, 1, rx);
      frame({8'h0, OP_WRITE, rows[k].addr, rows[k].data}, 5, rx);
      frame({8'h0, OP_READ, 7'h0, rows[k].addr[16:0], 8'h00}, 5, rx);
      chk("row data", rows[k].data, rx);
      chk("row mode", {7'h0, rows[k].m3}, {7'h0, mode3});
    end
    host.m3 = 1'b0;
    frame({OP_WRITE, 24'h01ffff, 8'h11, 8'h22}, 6, rx);
    frame({8'h0, OP_READ, 24'h000000, 8'h00}, 5, rx);
    chk("wrap", 8'h22, rx);
    frame({40'h0, OP_LATCH_CLR}, 1, rx);
    chk("latch clr", 8'h00, {7'h0, write_enable_latch});
    frame({8'h0, OP_WRITE, 24'h000000, 8'h77}, 5, rx);
    frame({8'h0, OP_READ, 24'h000000, 8'h00}, 5, rx);
    chk("no latch", 8'h22, rx);
    frame({40'h0, OP_LATCH_SET}, 1, rx);
    frame({32'h0, OP_STATUS_WR, 8'h8c}, 2, rx);
    frame({32'h0, OP_STATUS_RD, 8'h00}, 2, rx);
    chk("status", 8'h8e, rx);
    chk("lock bit", 8'h01, {7'h0, lock});
    frame({8'h0, OP_WRITE, 24'h000000, 8'h99}, 5, rx);
    frame({8'h0, OP_READ, 24'h000000, 8'h00}, 5, rx);
    chk("protected", 8'h22, rx);
    @(negedge i_mclk) i_wp_n = 1'b0;
    frame({32'h0, OP_STATUS_WR, 8'h00}, 2, rx);
    chk("wp low", 8'h03, {6'h0, bp});
    @(negedge i_mclk) i_wp_n = 1'b1;
    frame({32'h0, OP_STATUS_WR, 8'h00}, 2, rx);
    chk("wp high", 8'h00, {6'h0, bp});
    frame({40'h0, OP_SLEEP}, 1, rx);
    chk("sleep on", 8'h01, {7'h0, sleep});
    frame({40'h0, OP_LATCH_CLR}, 1, rx);
    chk("asleep", 8'h01, {7'h0, write_enable_latch});
    frame({40'h0, OP_WAKE}, 1, rx);
    chk("sleep off", 8'h00, {7'h0, sleep});
    oe_seen = 1'b0;
    frame({32'h0, 8'hff, 8'h00}, 2, rx);
    chk("unknown op", 8'h00, {7'h0, oe_seen});
    host.start();
    host.xbyte(OP_READ, rx);
    host.xbyte(8'h01, rx);
    host.xbyte(8'hff, rx);
    host.xbyte(8'hfe, rx);
    host.set_hold(1'b0);
    chk("pause oe", 8'h00, {7'h0, so_oe});
    chk("selected", 8'h01, {7'h0, selected});
    host.set_hold(1'b1);
    host.xbyte(8'h00, rx);
    host.stop();
    chk("pause data", 8'h3c, rx);
    chk("deselect oe", 8'h00, {7'h0, so_oe});
    chk("latch before reset", 8'h01, {7'h0, write_enable_latch});
    @(negedge i_mclk) i_rst = 1'b1;
    repeat (6) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_mclk);
    chk("reset again", 8'h00, {so_oe, sleep, mode3, selected, write_enable_latch, bp, lock});
    end_sim();
  end
endmodule : spi_serial_memory_command_port_tb
